// [rtl/phj_alt_override_defs.vh]
// constants for the port h / port j alternate override block
`ifndef PHJ_ALT_OVERRIDE_DEFS_VH
`define PHJ_ALT_OVERRIDE_DEFS_VH

// register offsets on the plain register port
`define PHJ_OFS_CTRL 4'h0
`define PHJ_OFS_MASK_H 4'h1
`define PHJ_OFS_MASK_J 4'h2
`define PHJ_OFS_STATUS 4'h3
`define PHJ_OFS_IRQ_MASK 4'h4
`define PHJ_OFS_PINS_H 4'h5
`define PHJ_OFS_PINS_J 4'h6
`define PHJ_OFS_INEN_OVR_H 4'h7
`define PHJ_OFS_INEN_OVR_J 4'h8

// control register field positions
`define PHJ_CTRL_LCD_ON 0
`define PHJ_CTRL_PORT_MASK 1
`define PHJ_CTRL_GROUP_EN 2

// status and irq mask field positions
`define PHJ_STAT_CHG_H 0
`define PHJ_STAT_CHG_J 1

// reset values
`define PHJ_RST_CTRL 3'h0
`define PHJ_RST_MASK_H 8'h00
`define PHJ_RST_MASK_J 7'h00
`define PHJ_RST_STATUS 2'h0
`define PHJ_RST_IRQ_MASK 2'h0
`define PHJ_RST_PINS 16'h0000

// pin layout: bits 7:0 port h, bits 15:8 port j, bit 15 is the plain gpio
`define PHJ_J_BASE 8
`define PHJ_PLAIN_PIN 15

// front plane numbering of the shared pins
`define PHJ_FP_H_HI_FIRST 36
`define PHJ_FP_H_LO_FIRST 7
`define PHJ_FP_J_HI_FIRST 27
`define PHJ_FP_J1 34
`define PHJ_FP_J0 35
`define PHJ_FP_COUNT 40

`endif

// [rtl/phj_alt_override.v]
// alternate function override logic for the shared pins of port h and port j
`timescale 1ns/10ps
`include "phj_alt_override_defs.vh"

module phj_alt_override #(
    parameter HAS_PORT_HJ = 1,
    parameter ADDR_W = 4
) (
    input wire clk,
    input wire srst,
    // register port
    input wire [ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    output wire irq,
    // ordinary port registers, bits 7:0 port h, 15:8 port j
    input wire [15:0] port_data,
    input wire [15:0] port_dir,
    input wire pull_up_disable,
    // pads and lcd generator
    input wire [15:0] pin_in,
    input wire [`PHJ_FP_COUNT-1:0] front_plane_out,
    // override signals towards the pad cells
    output reg [15:0] pullup_override_en,
    output reg [15:0] pullup_override_val,
    output reg [15:0] direction_override_en,
    output reg [15:0] direction_override_val,
    output reg [15:0] outvalue_override_en,
    output reg [15:0] outvalue_override_val,
    output reg [15:0] input_enable_override_en,
    output reg [15:0] input_enable_override_val,
    // resolved pad controls
    output reg [15:0] pad_pullup,
    output reg [15:0] pad_dir,
    output reg [15:0] pad_out,
    output reg [15:0] pad_input_en,
    // analog segment path
    output reg [15:0] analog_pin_path,
    output reg [15:0] segment_drive_out,
    // pin change sources
    output wire [7:0] pin_change_src_h,
    output wire [6:0] pin_change_src_j
);

    // variant switch, small variant ties off the overrides, segment path and pin change logic; registers and pads still work
    localparam PRESENT = (HAS_PORT_HJ != 0) ? 1'b1 : 1'b0;

    // software visible state
    reg [2:0] ctrl_ff;
    reg [7:0] mask_h_ff;
    reg [6:0] mask_j_ff;
    reg [1:0] status_ff;
    reg [1:0] irq_mask_ff;
    reg [1:0] nxt_status;

    // pad input synchronisers
    reg [15:0] sync1_ff;
    reg [15:0] sync2_ff;
    reg [15:0] prev_ff;

    wire lcd_drive_on;
    wire segment_port_mask;
    wire pin_change_group_en;
    wire [15:0] change_mask;
    wire [15:0] pin_toggled;
    wire chg_h;
    wire chg_j;
    wire wr_status;
    wire [1:0] irq_pending;

    assign lcd_drive_on = ctrl_ff[`PHJ_CTRL_LCD_ON] & PRESENT;
    assign segment_port_mask = ctrl_ff[`PHJ_CTRL_PORT_MASK];
    assign pin_change_group_en = ctrl_ff[`PHJ_CTRL_GROUP_EN];
    // plain pin has no mask bit, kept zero
    assign change_mask = {1'b0, mask_j_ff, mask_h_ff};

    // register writes
    always @(posedge clk) begin
        if (srst) begin
            ctrl_ff <= `PHJ_RST_CTRL;
            mask_h_ff <= `PHJ_RST_MASK_H;
            mask_j_ff <= `PHJ_RST_MASK_J;
            irq_mask_ff <= `PHJ_RST_IRQ_MASK;
        end else if (reg_wr) begin
            case (reg_addr)
                `PHJ_OFS_CTRL: begin
                    ctrl_ff <= reg_wdata[2:0];
                end
                `PHJ_OFS_MASK_H: begin
                    mask_h_ff <= reg_wdata;
                end
                `PHJ_OFS_MASK_J: begin
                    mask_j_ff <= reg_wdata[6:0];
                end
                `PHJ_OFS_IRQ_MASK: begin
                    irq_mask_ff <= reg_wdata[1:0];
                end
                default: begin
                    ctrl_ff <= ctrl_ff;
                end
            endcase
        end
    end

    // two flops before any logic looks at a pad
    always @(posedge clk) begin
        if (srst) begin
            sync1_ff <= `PHJ_RST_PINS;
            sync2_ff <= `PHJ_RST_PINS;
        end else begin
            sync1_ff <= pin_in;
            sync2_ff <= sync1_ff;
        end
    end

    // history for toggle detection, fed from the settled second flop only
    always @(posedge clk) begin
        if (srst) begin
            prev_ff <= `PHJ_RST_PINS;
        end else begin
            prev_ff <= sync2_ff;
        end
    end

    // sources from the second flop only, bit order kept
    assign pin_change_src_h = sync2_ff[7:0] & {8{PRESENT}};
    assign pin_change_src_j = sync2_ff[14:8] & {7{PRESENT}};

    // masked toggle on either port raises an event
    assign pin_toggled = (sync2_ff ^ prev_ff) & change_mask;
    assign chg_h = (|pin_toggled[7:0]) & pin_change_group_en & PRESENT;
    assign chg_j = (|pin_toggled[14:8]) & pin_change_group_en & PRESENT;
    assign wr_status = reg_wr && (reg_addr == `PHJ_OFS_STATUS);

    // sticky status, write one to clear, a new event beats the clear
    always @* begin
        nxt_status = status_ff;
        if (wr_status) begin
            nxt_status = status_ff & ~reg_wdata[1:0];
        end
        if (chg_h) begin
            nxt_status[`PHJ_STAT_CHG_H] = 1'b1;
        end
        if (chg_j) begin
            nxt_status[`PHJ_STAT_CHG_J] = 1'b1;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            status_ff <= `PHJ_RST_STATUS;
        end else begin
            status_ff <= nxt_status;
        end
    end

    // level interrupt while any unmasked event is pending
    assign irq_pending = status_ff & irq_mask_ff;
    assign irq = |irq_pending;

    // read data, valid only in the cycle after the strobe
    always @(posedge clk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `PHJ_OFS_CTRL: begin
                    reg_rdata <= {5'h00, ctrl_ff};
                end
                `PHJ_OFS_MASK_H: begin
                    reg_rdata <= mask_h_ff;
                end
                `PHJ_OFS_MASK_J: begin
                    reg_rdata <= {1'b0, mask_j_ff};
                end
                `PHJ_OFS_STATUS: begin
                    reg_rdata <= {6'h00, status_ff};
                end
                `PHJ_OFS_IRQ_MASK: begin
                    reg_rdata <= {6'h00, irq_mask_ff};
                end
                `PHJ_OFS_PINS_H: begin
                    reg_rdata <= sync2_ff[7:0];
                end
                `PHJ_OFS_PINS_J: begin
                    reg_rdata <= sync2_ff[15:8];
                end
                `PHJ_OFS_INEN_OVR_H: begin
                    reg_rdata <= input_enable_override_en[7:0];
                end
                `PHJ_OFS_INEN_OVR_J: begin
                    reg_rdata <= input_enable_override_en[15:8];
                end
                default: begin
                    reg_rdata <= 8'h00; // unmapped reads as zero
                end
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // front plane number wired to a pin, only meaningful on usable pins
    function integer fp_index;
        input integer pin;
        begin
            case (pin)
                0, 1, 2, 3: begin
                    fp_index = `PHJ_FP_H_LO_FIRST + 3 - pin;
                end
                4, 5, 6, 7: begin
                    fp_index = `PHJ_FP_H_HI_FIRST + 7 - pin;
                end
                8: begin
                    fp_index = `PHJ_FP_J0;
                end
                9: begin
                    fp_index = `PHJ_FP_J1;
                end
                10, 11, 12, 13, 14: begin
                    fp_index = `PHJ_FP_J_HI_FIRST + 14 - pin;
                end
                default: begin
                    fp_index = 0; // plain pin, no front plane behind it
                end
            endcase
        end
    endfunction

    // per pin override and pad resolution
    genvar i;
    generate
        for (i = 0; i < 16; i = i + 1) begin : g_pin
            // front plane feeding this pin, only meaningful where usable
            localparam integer FP_IDX = fp_index(i);
            // the plain j pin and the small variant get no alternate use
            localparam USABLE = (i != `PHJ_PLAIN_PIN) ? PRESENT : 1'b0;

            wire nxt_pullup_override_en;
            wire nxt_direction_override_en;
            wire nxt_input_enable_override_en;
            wire nxt_seg;
            wire nxt_pullup;
            wire nxt_dir;
            wire nxt_out;
            wire nxt_inen;
            wire nxt_pullup_override_val;
            wire nxt_direction_override_val;
            wire nxt_outvalue_override_en;
            wire nxt_outvalue_override_val;
            wire nxt_input_enable_override_val;

            // forced values are constants, each still has its own net
            assign nxt_pullup_override_val = 1'b0;
            assign nxt_direction_override_val = 1'b0;
            assign nxt_outvalue_override_en = 1'b0;
            assign nxt_outvalue_override_val = 1'b0;
            assign nxt_input_enable_override_val = 1'b0;
            assign nxt_pullup_override_en = USABLE & lcd_drive_on;
            assign nxt_direction_override_en = USABLE & lcd_drive_on;
            // input stage disabled only while the pin really serves as segment
            assign nxt_input_enable_override_en = USABLE & change_mask[i] & pin_change_group_en
                & lcd_drive_on & segment_port_mask;
            if (i < `PHJ_J_BASE) begin : g_h
                assign nxt_seg = USABLE & front_plane_out[FP_IDX];
            end else if (i != `PHJ_PLAIN_PIN) begin : g_j
                assign nxt_seg = USABLE & front_plane_out[FP_IDX];
            end else begin : g_plain
                assign nxt_seg = 1'b0;
            end

            // ordinary path when an enable is low, forced values are all zero
            assign nxt_pullup = nxt_pullup_override_en ? nxt_pullup_override_val
                : (~port_dir[i] & port_data[i] & ~pull_up_disable);
            assign nxt_dir = nxt_direction_override_en ? nxt_direction_override_val : port_dir[i];
            assign nxt_out = nxt_outvalue_override_en ? nxt_outvalue_override_val : port_data[i];
            assign nxt_inen = nxt_input_enable_override_en ? nxt_input_enable_override_val : 1'b1;

            // override bundle, registered so pads never see decode glitches
            always @(posedge clk) begin
                if (srst) begin
                    pullup_override_en[i] <= 1'b0;
                    pullup_override_val[i] <= 1'b0;
                    direction_override_en[i] <= 1'b0;
                    direction_override_val[i] <= 1'b0;
                    outvalue_override_en[i] <= 1'b0;
                    outvalue_override_val[i] <= 1'b0;
                    input_enable_override_en[i] <= 1'b0;
                    input_enable_override_val[i] <= 1'b0;
                end else begin
                    pullup_override_en[i] <= nxt_pullup_override_en;
                    pullup_override_val[i] <= nxt_pullup_override_val;
                    direction_override_en[i] <= nxt_direction_override_en;
                    direction_override_val[i] <= nxt_direction_override_val;
                    outvalue_override_en[i] <= nxt_outvalue_override_en;
                    outvalue_override_val[i] <= nxt_outvalue_override_val;
                    input_enable_override_en[i] <= nxt_input_enable_override_en;
                    input_enable_override_val[i] <= nxt_input_enable_override_val;
                end
            end

            // resolved pad controls, input stage left on out of reset
            always @(posedge clk) begin
                if (srst) begin
                    pad_pullup[i] <= 1'b0;
                    pad_dir[i] <= 1'b0;
                    pad_out[i] <= 1'b0;
                    pad_input_en[i] <= 1'b1;
                end else begin
                    pad_pullup[i] <= nxt_pullup;
                    pad_dir[i] <= nxt_dir;
                    pad_out[i] <= nxt_out;
                    pad_input_en[i] <= nxt_inen;
                end
            end

            // analog segment path, kept apart from the digital pad controls
            always @(posedge clk) begin
                if (srst) begin
                    analog_pin_path[i] <= 1'b0;
                    segment_drive_out[i] <= 1'b0;
                end else begin
                    analog_pin_path[i] <= USABLE & lcd_drive_on;
                    segment_drive_out[i] <= nxt_seg;
                end
            end
        end
    endgenerate

endmodule

// [verification/phj_pin_side.sv]
// pad and lcd glass model on the far side of the override block
`timescale 1ns/10ps
module phj_pin_side (
    input wire clk,
    input wire [15:0] pad_dir,
    input wire [15:0] pad_out,
    input wire [15:0] pad_pullup,
    input wire [15:0] ext_on,
    input wire [15:0] ext_lvl,
    input wire [5:0] seg_sel,
    input wire seg_on,
    output wire [15:0] pin_in,
    output wire [39:0] front_plane_out
);
    logic [15:0] last_ff = 16'h0000;
    // an undriven pad without pull-up wanders, so show the inverse of its last level
    assign pin_in = (pad_dir & pad_out) | (~pad_dir & ext_on & ext_lvl)
        | (~pad_dir & ~ext_on & (pad_pullup | ~last_ff));
    // one lit front plane at a time, easy to trace to its pin
    assign front_plane_out = 40'(seg_on) << seg_sel;
    always @(posedge clk) begin
        last_ff <= pin_in;
    end
endmodule

// [verification/phj_alt_override_monitor.sv]
// checker on the override block's ports
`timescale 1ns/10ps
`include "phj_alt_override_defs.vh"
module phj_alt_override_monitor (
    input wire clk,
    input wire srst,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire [15:0] port_dir,
    input wire [15:0] pin_in,
    input wire [`PHJ_FP_COUNT-1:0] front_plane_out,
    input wire [15:0] pullup_override_en,
    input wire [15:0] pullup_override_val,
    input wire [15:0] direction_override_en,
    input wire [15:0] direction_override_val,
    input wire [15:0] outvalue_override_en,
    input wire [15:0] outvalue_override_val,
    input wire [15:0] input_enable_override_en,
    input wire [15:0] pad_dir,
    input wire [15:0] pad_input_en,
    input wire [15:0] segment_drive_out,
    input wire [7:0] pin_change_src_h,
    input wire [6:0] pin_change_src_j
);
    wire [`PHJ_FP_COUNT-1:0] fp = front_plane_out;
    // expected front plane per pin, the plain pin has none
    wire [15:0] seg_map = {1'b0, fp[27], fp[28], fp[29], fp[30], fp[31], fp[34], fp[35],
        fp[36], fp[37], fp[38], fp[39], fp[7], fp[8], fp[9], fp[10]};
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // two clean edges fill the input synchroniser
    sequence s_run2;
        !srst [*2];
    endsequence
    a_pullup_forced_off: assert property (pullup_override_val == 16'h0000)
        else $error("pull-up override value set");
    a_dir_with_lcd: assert property (direction_override_en == pullup_override_en
        && direction_override_val == 16'h0000) else $error("direction override wrong");
    a_outvalue_never_set: assert property (outvalue_override_en == 16'h0000
        && outvalue_override_val == 16'h0000) else $error("output value overridden");
    a_inen_needs_lcd: assert property ((input_enable_override_en & ~pullup_override_en) == 0)
        else $error("input override without lcd");
    a_plain_pin_quiet: assert property ({pullup_override_en[15], input_enable_override_en[15]}
        == 2'h0) else $error("plain pin overridden");
    a_src_h_order: assert property (s_run2 |=> pin_change_src_h == $past(pin_in[7:0], 2))
        else $error("port h change source wrong");
    a_src_j_order: assert property (s_run2 |=> pin_change_src_j == $past(pin_in[14:8], 2))
        else $error("port j change source wrong");
    a_segment_map: assert property (!srst |=> segment_drive_out == $past(seg_map))
        else $error("segment mapping wrong");
    a_dir_follows_reg: assert property (!srst |=>
        pad_dir == ($past(port_dir) & ~direction_override_en)) else $error("pad direction wrong");
    a_input_en_release: assert property (pad_input_en == ~input_enable_override_en)
        else $error("pad input enable wrong");
    a_read_one_cycle: assert property (reg_rdata != 8'h00 |-> $past(reg_rd))
        else $error("read data outside its cycle");
endmodule
bind phj_alt_override phj_alt_override_monitor u_phj_alt_override_monitor (.clk, .srst,
    .reg_rd, .reg_rdata, .port_dir, .pin_in, .front_plane_out, .pullup_override_en,
    .pullup_override_val, .direction_override_en, .direction_override_val,
    .outvalue_override_en, .outvalue_override_val, .input_enable_override_en, .pad_dir,
    .pad_input_en, .segment_drive_out, .pin_change_src_h, .pin_change_src_j);

// [verification/test_port_h_j_alternate_override.sv]
// self-checking bench for the port h / port j override block
`timescale 1ns/10ps
`include "phj_alt_override_defs.vh"
module test_port_h_j_alternate_override;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] port_data = 16'hff0f;
    logic [15:0] port_dir = 16'h00f0;
    logic pull_up_disable = 1'b0;
    logic [15:0] ext_lvl = 16'h0000;
    logic [5:0] seg_sel = 6'h00;
    logic seg_on = 1'b0;
    wire irq;
    wire [7:0] reg_rdata, pin_change_src_h;
    wire [6:0] pin_change_src_j;
    wire [39:0] front_plane_out;
    wire [15:0] pin_in, pullup_override_en, pullup_override_val, direction_override_en;
    wire [15:0] direction_override_val, outvalue_override_en, outvalue_override_val;
    wire [15:0] input_enable_override_en, input_enable_override_val, pad_pullup, pad_dir;
    wire [15:0] pad_out, pad_input_en, analog_pin_path, segment_drive_out;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int fpn [15] = '{10, 9, 8, 7, 39, 38, 37, 36, 35, 34, 31, 30, 29, 28, 27};

    phj_alt_override u_phj_alt_override (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .irq, .port_data, .port_dir, .pull_up_disable, .pin_in, .front_plane_out,
        .pullup_override_en, .pullup_override_val, .direction_override_en,
        .direction_override_val, .outvalue_override_en, .outvalue_override_val,
        .input_enable_override_en, .input_enable_override_val, .pad_pullup, .pad_dir,
        .pad_out, .pad_input_en, .analog_pin_path, .segment_drive_out, .pin_change_src_h,
        .pin_change_src_j);
    phj_pin_side u_phj_pin_side (.clk, .pad_dir, .pad_out, .pad_pullup, .ext_on(16'hffff),
        .ext_lvl, .seg_sel, .seg_on, .pin_in, .front_plane_out);

    always #4 clk = ~clk;

    task automatic final_report();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk16({8'h00, reg_rdata}, {8'h00, exp});
    endtask
    // one edge for the register, one for the registered output
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    // hang guard, the sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            final_report();
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        settle();
        chk16(pad_dir, 16'h00f0);
        chk16(pad_pullup, 16'hff0f);
        rd(`PHJ_OFS_CTRL, 8'h00);
        wr(`PHJ_OFS_MASK_H, 8'h5a);
        wr(`PHJ_OFS_MASK_J, 8'h7f);
        // every control combination, group enable and port mask gate the input override
        for (int c = 0; c < 8; c++) begin
            wr(`PHJ_OFS_CTRL, 8'(c));
            settle();
            chk16(input_enable_override_en, (c == 7) ? 16'h7f5a : 16'h0000);
            chk16(pullup_override_en, c[0] ? 16'h7fff : 16'h0000);
            chk16(direction_override_en, c[0] ? 16'h7fff : 16'h0000);
            chk16(analog_pin_path, c[0] ? 16'h7fff : 16'h0000);
            chk16(pad_input_en, (c == 7) ? 16'h80a5 : 16'hffff);
            chk16(input_enable_override_val, 16'h0000);
        end
        chk16(pad_dir, 16'h0000);
        chk16(pad_pullup, 16'h8000);
        chk16(pad_out | outvalue_override_en, 16'hff0f);
        rd(`PHJ_OFS_INEN_OVR_H, 8'h5a);
        rd(`PHJ_OFS_INEN_OVR_J, 8'h7f);
        @(posedge clk);
        seg_on <= 1'b1;
        for (int i = 0; i < 15; i++) begin
            @(posedge clk);
            seg_sel <= 6'(fpn[i]);
            settle();
            chk16(segment_drive_out, 16'h0001 << i);
        end
        @(posedge clk);
        ext_lvl <= 16'ha5c3;
        settle();
        chk16({1'b0, pin_change_src_j, pin_change_src_h}, 16'h25c3);
        rd(`PHJ_OFS_PINS_J, 8'ha5);
        wr(`PHJ_OFS_STATUS, 8'h03);
        wr(`PHJ_OFS_IRQ_MASK, 8'h01);
        rd(`PHJ_OFS_STATUS, 8'h00);
        @(posedge clk);
        ext_lvl <= 16'h25c1;
        repeat (5) @(posedge clk);
        rd(`PHJ_OFS_STATUS, 8'h01);
        chk16({15'h0000, irq}, 16'h0001);
        wr(`PHJ_OFS_IRQ_MASK, 8'h00);
        #1;
        chk16({15'h0000, irq}, 16'h0000);
        wr(`PHJ_OFS_STATUS, 8'h01);
        rd(`PHJ_OFS_STATUS, 8'h00);
        wr(4'hf, 8'hff);
        rd(4'hf, 8'h00);
        rd(`PHJ_OFS_CTRL, 8'h07);
        // lcd off again: pads follow the ordinary registers and the pull-up formula
        wr(`PHJ_OFS_CTRL, 8'h00);
        port_dir <= 16'h0f0f;
        port_data <= 16'h5555;
        pull_up_disable <= 1'b1;
        settle();
        chk16(pad_dir, 16'h0f0f);
        chk16(pad_out, 16'h5555);
        chk16(pad_pullup, 16'h0000);
        @(posedge clk);
        pull_up_disable <= 1'b0;
        settle();
        chk16(pad_pullup, 16'h5050);
        final_report();
    end
endmodule
